// File: rtl/drcc_pkg.sv
// Purpose: shared constants and carriers of the disc record command block
// Assumes: 16-bit processor words carried in the low bits of 32-bit APB data
// Notes:   command codes are the function field of a control pulse
package drcc_pkg;
  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_SENSE = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_GAP = 8'h10;
  localparam logic CTRL_MASK_RST = 1'b0;
  localparam int CTRL_MASK_BIT = 0;
  // ------------------------------------------------------------------
  // control pulse command codes
  // ------------------------------------------------------------------
  localparam logic [5:0] CMD_RTZ = 6'h00;
  localparam logic [5:0] CMD_SEEK = 6'h01;
  localparam logic [5:0] CMD_CHAN = 6'h03;
  localparam logic [5:0] CMD_FORMAT = 6'h05;
  localparam logic [5:0] CMD_RECORD = 6'h06;
  localparam logic [5:0] CMD_BUS = 6'h07;
  localparam logic [5:0] CMD_STOP = 6'h08;
  localparam logic [5:0] CMD_ACK = 6'h0c;
  // ------------------------------------------------------------------
  // setup word fields; processor bit 1 is the word's top bit
  // ------------------------------------------------------------------
  localparam int SU_WRITE_BIT = 15;
  localparam int SU_UNIT_LSB = 10;
  localparam int SU_HEAD_LSB = 0;
  localparam logic [7:0] TRACK_MAX = 8'hca;
  localparam logic [2:0] EXCESS_MAX = 3'h4;
  localparam logic [6:0] GAP_TAIL_BITS = 7'h40;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEEK_BUSY_NS = 50000;
  localparam int SEEK_BUSY_CYC = (SEEK_BUSY_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // ------------------------------------------------------------------
  // drive carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic index;
    logic eor;
    logic word_tick;
    logic bit_tick;
    logic [15:0] rd_word;
    logic chk_fail;
    logic addr_miss;
    logic online;
    logic unsafe;
    logic fmt_end;
    logic [7:0] cur_track;
    logic [3:0] seek_done;
    logic [3:0] seeking;
  } drcc_drv_in_s;
  typedef struct packed {
    logic [1:0] unit;
    logic [4:0] head;
    logic [15:0] rec_addr;
    logic rd_gate;
    logic wr_gate;
    logic [15:0] wr_word;
    logic wr_strobe;
    logic trailer;
    logic ones;
    logic seek_req;
    logic rtz_req;
    logic [7:0] seek_track;
  } drcc_drv_out_s;
endpackage

// File: rtl/drcc_top.sv
// Purpose: command, transfer and sense logic of a disc control unit
// Assumes: drive gives word and bit ticks synchronous to clk_i
// Notes:   registers sit on an APB slave with zero wait states
// Overview of operation
// R1: setup word bit 1 selects read (0) or write (1) of one record
// R2: unit, head from setup one, record address from setup two, no motion
// R3: read busy ends on index, input rate miss or end of record
// R4: stop or end-of-range stops delivery, reading continues to record end
// R5: longer read count also delivers the record check word
// R6: write ends on index, rate miss, stop, end-of-range; trailer unless index
// R7: write busy from setup one to the first termination
// R8: write excess up to 4 words only shrinks gap; more may corrupt
// R9: host outputs first write word in 83 us, later ones in 12 us
// R10: host inputs first read word in 96 us, later in 12 us, stop in 12
// R11: channel carries n+2 output words; reads turn direction after setups
// R12: bus mode command selects bus transfer until channel mode or clear
// R13: stop ends bus write or format; after gap word ones run to origin
// R14: host stops short reads to avoid a false rate error
// R15: masked busy fall sets interrupt; commands clear; seek busy excluded
// R16: masked seek completion interrupts, deferred while busy; zero seek now
// R17: sense bits for word ready, not busy and not interrupting
// R18: data error for check or rate failure; cleared by most commands
// R19: setup error for address miss, range, offline, index, unit, unsafe; the code makes no unit check
// R20: seek beyond track 202 returns to zero and completes
// R21: one not-seeking sense bit for each of four units
// R22: format writes gap 64 bits past index
`timescale 1ns/1ns
`default_nettype none
module drcc_top #(
  parameter int SEEK_BUSY_CYCLES = drcc_pkg::SEEK_BUSY_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // channel side
  input wire logic chan_eor_i,
  output logic chan_input_o,
  output logic irq_o,
  // drive side
  input wire drcc_pkg::drcc_drv_in_s drv_i,
  output drcc_pkg::drcc_drv_out_s drv_o
);
  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SU1, ST_SU2, ST_READ, ST_DRAIN, ST_WRITE,
    ST_FMT, ST_ONES, ST_TAIL, ST_SEEK_SU
  } drcc_state_e;
  drcc_state_e state;
  logic acc, wr_acc, rd_acc, mapped;
  logic cmd_wr, data_wr, data_rd;
  logic [5:0] cmd;
  logic [15:0] wdat;
  logic op_busy, op_busy_q, seek_busy, busy;
  logic [31:0] seek_cnt;
  logic is_write, fmt, bus_mode, mask, stopped, gap_seen;
  logic [15:0] hold;
  logic hold_full;
  logic data_err, setup_err, irq, past_end;
  logic [2:0] excess;
  logic [6:0] tail_cnt;
  logic [3:0] seek_pend;
  logic stop_ev, rate_miss, word_ready;
  logic [31:0] sense;

  // ------------------------------------------------------------------
  // apb decode: always ready, unmapped addresses answer with an error
  // ------------------------------------------------------------------
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i == drcc_pkg::REG_CMD ||
                  paddr_i == drcc_pkg::REG_DATA ||
                  paddr_i == drcc_pkg::REG_SENSE ||
                  paddr_i == drcc_pkg::REG_CTRL ||
                  paddr_i == drcc_pkg::REG_GAP;
  assign wr_acc = acc && pwrite_i && mapped;
  assign rd_acc = acc && !pwrite_i && mapped;
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign cmd_wr = wr_acc && paddr_i == drcc_pkg::REG_CMD;
  assign data_wr = wr_acc && (paddr_i == drcc_pkg::REG_DATA ||
                              paddr_i == drcc_pkg::REG_GAP);
  assign data_rd = rd_acc && paddr_i == drcc_pkg::REG_DATA;
  assign cmd = pwdata_i[5:0];
  assign wdat = pwdata_i[15:0];

  // stop from software in either mode or from the channel's range end outside bus mode
  assign stop_ev = (cmd_wr && cmd == drcc_pkg::CMD_STOP) ||
                   (!bus_mode && chan_eor_i);
  // a word tick finding the holding word unserviced misses the rate
  assign rate_miss = drv_i.word_tick && !stopped &&
                     ((state == ST_READ && hold_full) ||
                      ((state == ST_WRITE || state == ST_FMT) && !hold_full));
  assign op_busy = state != ST_IDLE && state != ST_SEEK_SU;
  assign busy = op_busy || seek_busy;
  // ready: a setup word awaited, a read word held, or a write slot free
  assign word_ready = state == ST_SU1 || state == ST_SU2 ||
                      state == ST_SEEK_SU ||
                      (state == ST_READ && hold_full && !stopped) ||
                      ((state == ST_WRITE || state == ST_FMT) &&
                       !hold_full && !stopped); // R17
  assign sense = {16'h0, ~drv_i.seeking, 3'h0,
                  excess > drcc_pkg::EXCESS_MAX, past_end && excess != 3'h0,
                  chan_input_o, bus_mode, !irq, !setup_err, !data_err,
                  !busy, word_ready}; // R17 R21

  // ------------------------------------------------------------------
  // read data register: flop, so data outputs never glitch
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        drcc_pkg::REG_DATA: prdata_o <= {16'h0, hold};
        drcc_pkg::REG_SENSE: prdata_o <= sense;
        drcc_pkg::REG_CTRL: prdata_o <= {31'h0, mask};
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      is_write <= 1'b0;
      fmt <= 1'b0;
      drv_o <= '0;
      tail_cnt <= 7'h0;
    end else begin
      drv_o.wr_strobe <= 1'b0;
      drv_o.trailer <= 1'b0;
      drv_o.seek_req <= 1'b0;
      drv_o.rtz_req <= 1'b0;
      if (cmd_wr && (cmd == drcc_pkg::CMD_RECORD ||
                     cmd == drcc_pkg::CMD_FORMAT)) begin
        state <= ST_SU1; // R2
        fmt <= cmd == drcc_pkg::CMD_FORMAT;
      end else if (cmd_wr && (cmd == drcc_pkg::CMD_SEEK ||
                              cmd == drcc_pkg::CMD_RTZ)) begin
        state <= ST_SEEK_SU;
      end else begin
        unique case (state)
          ST_IDLE: begin
          end
          ST_SEEK_SU: if (data_wr) begin
            state <= ST_IDLE;
            drv_o.unit <= wdat[drcc_pkg::SU_UNIT_LSB +: 2];
            drv_o.seek_track <= wdat[7:0];
            if (wdat[7:0] > drcc_pkg::TRACK_MAX) begin
              drv_o.rtz_req <= 1'b1; // R20
            end else begin
              drv_o.seek_req <= 1'b1;
            end
          end
          ST_SU1: if (data_wr) begin
            drv_o.unit <= wdat[drcc_pkg::SU_UNIT_LSB +: 2]; // R2
            drv_o.head <= wdat[drcc_pkg::SU_HEAD_LSB +: 5];
            is_write <= wdat[drcc_pkg::SU_WRITE_BIT] || fmt; // R1
            state <= ST_SU2;
          end
          ST_SU2: if (data_wr) begin
            drv_o.rec_addr <= wdat; // R2
            if (fmt) begin
              state <= ST_FMT;
              drv_o.wr_gate <= 1'b1;
            end else if (is_write) begin
              state <= ST_WRITE; // R1
              drv_o.wr_gate <= 1'b1;
            end else begin
              state <= ST_READ; // R1
              drv_o.rd_gate <= 1'b1;
            end
          end
          ST_READ: begin
            // check word arrives as a last word if still transferring
            if (drv_i.index || rate_miss || drv_i.eor ||
                drv_i.addr_miss) begin
              state <= ST_IDLE; // R3 R5
              drv_o.rd_gate <= 1'b0;
            end
          end
          ST_WRITE: begin
            if (drv_i.index) begin
              state <= ST_IDLE; // R6 R7
              drv_o.wr_gate <= 1'b0;
            end else if (rate_miss || stop_ev || drv_i.addr_miss) begin
              state <= ST_IDLE; // R6 R7
              drv_o.trailer <= 1'b1;
              drv_o.wr_gate <= 1'b0;
            end else if (drv_i.word_tick && hold_full) begin
              drv_o.wr_word <= hold;
              drv_o.wr_strobe <= 1'b1;
            end
          end
          ST_FMT: begin
            if (drv_i.index) begin
              state <= ST_TAIL; // R22
              tail_cnt <= 7'h0;
            end else if ((stop_ev && gap_seen) || rate_miss) begin
              state <= ST_ONES; // R13
              drv_o.ones <= 1'b1;
            end else if (stop_ev) begin
              state <= ST_IDLE; // R13
              drv_o.wr_gate <= 1'b0;
            end else if (drv_i.word_tick && hold_full) begin
              drv_o.wr_word <= hold;
              drv_o.wr_strobe <= 1'b1;
            end
          end
          ST_ONES: if (drv_i.index) begin
            state <= ST_TAIL; // R13 R22
            tail_cnt <= 7'h0;
          end
          ST_TAIL: begin
            drv_o.ones <= 1'b1;
            if (drv_i.bit_tick) begin
              tail_cnt <= tail_cnt + 7'h1; // R22
            end
            if (drv_i.bit_tick &&
                tail_cnt == drcc_pkg::GAP_TAIL_BITS - 7'h1) begin
              state <= ST_IDLE;
              drv_o.ones <= 1'b0;
              drv_o.wr_gate <= 1'b0;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // holding word between processor and drive
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hold <= 16'h0;
      hold_full <= 1'b0;
      stopped <= 1'b0;
      gap_seen <= 1'b0;
    end else begin
      if (state == ST_SU2 && data_wr) begin
        hold_full <= 1'b0;
        stopped <= 1'b0;
        gap_seen <= 1'b0;
      end else if (state == ST_READ) begin
        // delivery ends on stop, the disc keeps being read
        if (stop_ev) begin
          stopped <= 1'b1; // R4
        end
        if (drv_i.word_tick && !stopped && !stop_ev) begin
          hold <= drv_i.rd_word; // R5
          hold_full <= 1'b1;
        end else if (data_rd) begin
          hold_full <= 1'b0;
        end
      end else if (state == ST_WRITE || state == ST_FMT) begin
        if (data_wr && !hold_full) begin
          hold <= wdat;
          hold_full <= 1'b1;
          gap_seen <= gap_seen || paddr_i == drcc_pkg::REG_GAP;
        end else if (drv_i.word_tick) begin
          hold_full <= 1'b0;
        end
      end else if (data_rd) begin
        hold_full <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // mode and mask: bus mode holds until channel mode or reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus_mode <= 1'b0;
      mask <= drcc_pkg::CTRL_MASK_RST;
    end else begin
      if (cmd_wr && cmd == drcc_pkg::CMD_BUS) begin
        bus_mode <= 1'b1; // R12
      end else if (cmd_wr && cmd == drcc_pkg::CMD_CHAN) begin
        bus_mode <= 1'b0; // R12
      end
      if (wr_acc && paddr_i == drcc_pkg::REG_CTRL) begin
        mask <= pwdata_i[drcc_pkg::CTRL_MASK_BIT];
      end
    end
  end
  // channel reads see two output setup words, then turn to input
  assign chan_input_o = !bus_mode && state == ST_READ; // R11

  // ------------------------------------------------------------------
  // error senses: events win over the clearing command
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_err <= 1'b0;
      setup_err <= 1'b0;
    end else begin
      if (cmd_wr && cmd != drcc_pkg::CMD_STOP &&
          cmd != drcc_pkg::CMD_ACK) begin
        data_err <= 1'b0; // R18
        setup_err <= 1'b0; // R19
      end
      if (rate_miss || (state == ST_READ && drv_i.chk_fail)) begin
        data_err <= 1'b1; // R18
      end
      if ((op_busy && (drv_i.addr_miss || drv_i.unsafe)) ||
          ((state == ST_READ || state == ST_WRITE) && drv_i.index) ||
          (state == ST_SU2 && data_wr && !drv_i.online) ||
          (state == ST_SEEK_SU && data_wr &&
           wdat[7:0] > drcc_pkg::TRACK_MAX)) begin
        setup_err <= 1'b1; // R19 R20
      end
    end
  end

  // ------------------------------------------------------------------
  // write overrun past the formatted data field
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      past_end <= 1'b0;
      excess <= 3'h0;
    end else if (state == ST_SU2 && data_wr) begin
      past_end <= 1'b0;
      excess <= 3'h0;
    end else if (state == ST_WRITE) begin
      if (drv_i.fmt_end) begin
        past_end <= 1'b1;
      end
      // saturates one beyond the harmless limit, enough to report it
      if (past_end && drv_i.word_tick && hold_full &&
          excess <= drcc_pkg::EXCESS_MAX) begin
        excess <= excess + 3'h1; // R8
      end
    end
  end

  // ------------------------------------------------------------------
  // seek busy window, kept apart from operation busy
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      seek_busy <= 1'b0;
      seek_cnt <= 32'h0;
    end else if (drv_o.seek_req || drv_o.rtz_req) begin
      seek_busy <= 1'b1;
      seek_cnt <= 32'h0;
    end else if (seek_busy) begin
      seek_cnt <= seek_cnt + 32'h1;
      if (seek_cnt == 32'(SEEK_BUSY_CYCLES - 1)) begin
        seek_busy <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt flip-flop; seek completions wait while busy
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      op_busy_q <= 1'b0;
      irq <= 1'b0;
      seek_pend <= 4'h0;
    end else begin
      op_busy_q <= op_busy;
      if (cmd_wr) begin
        irq <= 1'b0; // R15 R16
      end
      seek_pend <= seek_pend | drv_i.seek_done; // R16
      if (mask && op_busy_q && !op_busy) begin
        irq <= 1'b1; // R15
      end
      if (mask && !op_busy && (seek_pend != 4'h0 ||
          drv_i.seek_done != 4'h0)) begin
        irq <= 1'b1; // R16
        seek_pend <= 4'h0;
      end
      // zero-track direct seek completes at once
      if (mask && drv_o.seek_req &&
          drv_o.seek_track == drv_i.cur_track) begin
        irq <= 1'b1; // R16
      end
    end
  end
  assign irq_o = irq;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_busy_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
    mask && $fell(op_busy) |=> irq;
  endproperty
  a_busy_irq: assert property (p_busy_irq) // R15
    else $error("busy fall did not interrupt");
  property p_read_dir;
    @(posedge clk_i) disable iff (!reset_n_i)
    state == ST_READ && !bus_mode |-> chan_input_o;
  endproperty
  a_read_dir: assert property (p_read_dir) // R11
    else $error("channel not turned to input");
  property p_err_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_wr && cmd == drcc_pkg::CMD_BUS && state == ST_IDLE
      |=> !data_err && !setup_err;
  endproperty
  a_err_clear: assert property (p_err_clear) // R18
    else $error("error sense not cleared");
  property p_mode_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !cmd_wr |=> $stable(bus_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // R12
    else $error("bus mode changed without command");
  property p_index_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    state == ST_READ && drv_i.index && !cmd_wr
      |=> state == ST_IDLE && setup_err;
  endproperty
  a_index_read: assert property (p_index_read) // R3
    else $error("index did not end read");
  property p_stop_trailer;
    @(posedge clk_i) disable iff (!reset_n_i)
    state == ST_WRITE && stop_ev && !drv_i.index &&
      !(cmd_wr && cmd != drcc_pkg::CMD_STOP)
      |=> drv_o.trailer && !drv_o.wr_gate;
  endproperty
  a_stop_trailer: assert property (p_stop_trailer) // R6
    else $error("stop did not close the record");
  property p_range;
    @(posedge clk_i) disable iff (!reset_n_i)
    state == ST_SEEK_SU && data_wr && !cmd_wr &&
      wdat[7:0] > drcc_pkg::TRACK_MAX
      |=> drv_o.rtz_req && setup_err ##1 seek_busy;
  endproperty
  a_range: assert property (p_range) // R20
    else $error("out of range seek not returned to zero");
  property p_tail;
    @(posedge clk_i) disable iff (!reset_n_i)
    state == ST_TAIL |-> tail_cnt < drcc_pkg::GAP_TAIL_BITS;
  endproperty
  a_tail: assert property (p_tail) // R22
    else $error("gap tail overran");
  property p_no_motion;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_wr && cmd == drcc_pkg::CMD_RECORD |=> (!drv_o.seek_req) [*2];
  endproperty
  a_no_motion: assert property (p_no_motion) // R2
    else $error("record command moved heads");
  c_read: cover property (@(posedge clk_i) state == ST_READ ##1
    state == ST_IDLE);
  c_write_stop: cover property (@(posedge clk_i) drv_o.trailer);
  c_tail: cover property (@(posedge clk_i) state == ST_TAIL ##1
    state == ST_IDLE);
  c_irq: cover property (@(posedge clk_i) $rose(irq_o));
endmodule
`default_nettype wire

// File: test/drcc_drive_model.sv
// Purpose: drive stand-in, a word per 40 cycles while gated
// Assumes: records hold three words; no index seen
// Notes: unit always online and safe
`timescale 1ns/1ns
`default_nettype none
module drcc_drive_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // controller side
  input wire drcc_pkg::drcc_drv_out_s ctl_i,
  input wire logic [3:0] seeking_i,
  output drcc_pkg::drcc_drv_in_s drv_o
);
  logic [5:0] tick_cnt;
  logic [1:0] word_cnt;
  // data lines toggle between words so stale values never match
  always_ff @(posedge clk_i) begin
    drv_o <= '0;
    drv_o.online <= 1'b1;
    drv_o.seeking <= seeking_i;
    drv_o.rd_word <= ~drv_o.rd_word;
    if (!reset_n_i || !(ctl_i.rd_gate || ctl_i.wr_gate)) begin
      tick_cnt <= 6'h00;
      word_cnt <= 2'h0;
    end else if (tick_cnt == 6'h27) begin
      tick_cnt <= 6'h00;
      word_cnt <= word_cnt + 2'h1;
      drv_o.word_tick <= (word_cnt != 2'h3);
      drv_o.rd_word <= {14'h0040, word_cnt};
      drv_o.eor <= (word_cnt == 2'h3) && ctl_i.rd_gate;
    end else begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end
endmodule
`default_nettype wire

// File: test/drcc_top_bench.sv
// Purpose: self-checking bench of the record command block
// Assumes: apb answers with no wait states
// Notes: seek busy shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, x) begin check_count++; if ((a) !== (x)) begin \
  miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, x); end end
module drcc_top_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] seeking = 4'h0;
  logic chan_eor = 1'b0;
  logic chan_in;
  logic irq;
  logic [31:0] q;
  logic e;
  drcc_pkg::drcc_drv_in_s drv_i;
  drcc_pkg::drcc_drv_out_s drv_o;
  int miscompares = 0;
  int check_count = 0;
  always #2 clk_i = ~clk_i;
  drcc_top #(.SEEK_BUSY_CYCLES(20)) DUT (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .chan_eor_i(chan_eor), .chan_input_o(chan_in), .irq_o(irq),
    .drv_i(drv_i), .drv_o(drv_o));
  drcc_drive_model drive (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ctl_i(drv_o), .seeking_i(seeking), .drv_o(drv_i));
  task automatic test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      if (++n > 20) begin
        miscompares++;
        test_done();
      end
      @(posedge clk_i);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [5:0] c);
    apb(1'b1, drcc_pkg::REG_CMD, {26'h0, c});
  endtask
  task automatic sense;
    apb(1'b0, drcc_pkg::REG_SENSE, 32'h0);
  endtask
  // polling bounded so a stuck flag ends the run
  task automatic wait_sense(input int b, input logic v);
    int n;
    n = 0;
    sense();
    while (q[b] !== v) begin
      if (++n > 400) begin
        miscompares++;
        test_done();
      end
      sense();
    end
  endtask
  task automatic wait_out(input int k);
    logic [2:0] t;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_i);
      t = {drv_o.rtz_req, drv_o.trailer, drv_o.wr_strobe};
      if (t[k] === 1'b1) return;
    end
    miscompares++;
    test_done();
  endtask
  task automatic t_reset;
    sense();
    `CHK(q[4:1], 4'hf)
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(e, 1'b1)
    cmd(drcc_pkg::CMD_CHAN);
    sense();
    `CHK(q[5], 1'b0)
    cmd(drcc_pkg::CMD_BUS);
    sense();
    `CHK(q[5], 1'b1)
  endtask
  task automatic t_read;
    apb(1'b1, drcc_pkg::REG_CTRL, 32'h1);
    cmd(drcc_pkg::CMD_RECORD);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h0403);
    sense();
    `CHK(q[1], 1'b0)
    apb(1'b1, drcc_pkg::REG_DATA, 32'h0055);
    @(negedge clk_i);
    `CHK({drv_o.unit, drv_o.head, drv_o.rd_gate}, 8'h47)
    `CHK(drv_o.rec_addr, 16'h0055)
    for (int k = 0; k < 3; k++) begin
      wait_sense(0, 1'b1);
      apb(1'b0, drcc_pkg::REG_DATA, 32'h0);
      `CHK(q[15:0], 16'h0100 + 16'(k))
    end
    cmd(drcc_pkg::CMD_STOP);
    sense();
    `CHK(q[1], 1'b0)
    wait_sense(1, 1'b1);
    repeat (2) @(negedge clk_i);
    `CHK({irq, q[2]}, 2'h3)
    cmd(drcc_pkg::CMD_ACK);
    @(negedge clk_i);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_write;
    apb(1'b1, drcc_pkg::REG_CTRL, 32'h0);
    cmd(drcc_pkg::CMD_RECORD);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h8800);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h0022);
    wait_sense(0, 1'b1);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h1234);
    wait_out(0);
    `CHK({drv_o.wr_gate, drv_o.unit, drv_o.wr_word}, 19'h61234)
    cmd(drcc_pkg::CMD_STOP);
    wait_out(1);
    sense();
    `CHK({q[1], drv_o.wr_gate, irq}, 3'h4)
  endtask
  task automatic t_seek;
    seeking <= 4'h5;
    cmd(drcc_pkg::CMD_SEEK);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h00cb);
    wait_out(2);
    wait_sense(1, 1'b1);
    `CHK({q[15:12], q[3]}, 5'h14)
  endtask
  // channel read: range end before the first word stops delivery only
  task automatic t_chan;
    cmd(drcc_pkg::CMD_CHAN);
    cmd(drcc_pkg::CMD_RECORD);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h0000);
    apb(1'b1, drcc_pkg::REG_DATA, 32'h0011);
    sense();
    `CHK({q[6], chan_in, q[1]}, 3'h6)
    chan_eor <= 1'b1;
    @(posedge clk_i);
    chan_eor <= 1'b0;
    sense();
    `CHK({q[1], q[0]}, 2'h0)
    wait_sense(1, 1'b1);
    `CHK({q[6], chan_in, q[2]}, 3'h1)
  endtask
  // reset held five cycles, then scenarios in turn
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_read();
    t_write();
    t_seek();
    t_chan();
    test_done();
  end
endmodule
`default_nettype wire
